// >>> rtl/plc_top.sv
// PLL operational controls: profile windows, power-down, loop mode.
// Assumes an APB master on CLK; status inputs come from other domains.
`timescale 1ns/100ps
module plc_top
   import plc_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [13:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Status from the loop (asynchronous)
   input wire logic HISTORY_VALID,
   input wire logic PHASE_LOCK_RAW,
   input wire logic FREQ_LOCK_RAW,
   // Power-down controls
   output logic SOFT_RESET_N,
   output logic OSC_SLEEP,
   output logic SYSTEM_CLOCK_INPUT_SLEEP,
   output logic REFIN_SLEEP,
   output logic TIME_TO_DIGITAL_CONVERTER_SLEEP,
   output logic OUTPUT_ANALOG_PLL_SLEEP,
   output logic DIST_SLEEP,
   output logic FULL_SLEEP,
   // Loop controls
   output logic [1:0] LOOP_SOURCE,
   output logic [2:0] SWITCH_MODE,
   output logic MANUAL_MODE,
   output logic [1:0] ACTIVE_REF,
   output logic PHASE_LOCKED,
   output logic FREQ_LOCKED
);
   logic [7:0] pwr_q;
   logic [7:0] loop_q;
   logic [3:0] srst_cnt_q;
   logic [1:0] hist_s_q, plock_s_q, flock_s_q;
   logic [11:0] idx;
   logic setup, acc_wr, acc_rd;
   logic in_prof;
   logic [1:0] prof_ref;
   logic [PROF_IDX_W-1:0] prof_idx;
   logic [7:0] prof_rdata;
   logic [31:0] rdata_d;
   logic hit;
   logic hold_f, free_f;
   plc_loop_type loop_d;

   // Register index from the word address
   assign idx = PADDR[13:2];
   assign setup = PSEL && !PENABLE;
   assign acc_wr = PSEL && PENABLE && PWRITE;
   assign acc_rd = setup && !PWRITE;

   // Profile window decode: same offsets in every reference window
   always_comb begin
      in_prof = 1'b0;
      prof_ref = 2'h0;
      prof_idx = '0;
      if (idx >= PROF_BASE && idx <= PROF_LAST) begin
         in_prof = 1'b1;
         prof_ref = 2'h0;
         prof_idx = PROF_IDX_W'(idx - PROF_BASE);
      end else if (idx >= PROF_B_BASE && idx <= PROF_B_LAST) begin
         in_prof = 1'b1;
         prof_ref = 2'h1;
         prof_idx = PROF_IDX_W'(idx - PROF_B_BASE);
      end else if (idx >= PROF_C_BASE && idx <= PROF_C_LAST) begin
         in_prof = 1'b1;
         prof_ref = 2'h2;
         prof_idx = PROF_IDX_W'(idx - PROF_C_BASE);
      end else if (idx >= PROF_D_BASE && idx <= PROF_D_LAST) begin
         in_prof = 1'b1;
         prof_ref = 2'h3;
         prof_idx = PROF_IDX_W'(idx - PROF_D_BASE);
      end
   end

   // Profile byte arrays
   plc_profile_bank u_bank (
      .clk(CLK),
      .rst_n(RSTN),
      .wr_en(acc_wr && in_prof),
      .ref_sel(prof_ref),
      .idx(prof_idx),
      .wdata(PWDATA[7:0]),
      .rdata(prof_rdata)
   );

   // Power-down register; bits other than the soft reset bit survive soft reset
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         pwr_q <= GEN_PWR_DOWN_RST;
      end else if (acc_wr && idx == GEN_PWR_DOWN_IDX) begin
         pwr_q <= PWDATA[7:0];
      end else if (srst_cnt_q == 4'h1) begin
         pwr_q[PD_SOFT_RESET] <= 1'b0;
      end
   end

   // Loop-mode register; reserved bit never stored
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         loop_q <= LOOP_MODE_RST;
      end else if (acc_wr && idx == LOOP_MODE_IDX) begin
         loop_q <= PWDATA[7:0] & LOOP_MODE_MASK;
      end
   end

   // Soft reset pulse counter, started by the reset bit
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         srst_cnt_q <= 4'h0;
      end else if (acc_wr && idx == GEN_PWR_DOWN_IDX &&
                   PWDATA[PD_SOFT_RESET]) begin
         srst_cnt_q <= SOFT_RST_CYCLES;
      end else if (srst_cnt_q != 4'h0) begin
         srst_cnt_q <= srst_cnt_q - 4'h1;
      end
   end

   // Soft reset output to the operating logic
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         SOFT_RESET_N <= 1'b1;
      end else begin
         SOFT_RESET_N <= !(pwr_q[PD_SOFT_RESET] ||
                           srst_cnt_q != 4'h0);
      end
   end

   // Sleep controls
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         OSC_SLEEP <= 1'b0;
         SYSTEM_CLOCK_INPUT_SLEEP <= 1'b0;
         REFIN_SLEEP <= 1'b0;
         TIME_TO_DIGITAL_CONVERTER_SLEEP <= 1'b0;
         OUTPUT_ANALOG_PLL_SLEEP <= 1'b0;
         DIST_SLEEP <= 1'b0;
         FULL_SLEEP <= 1'b0;
      end else begin
         OSC_SLEEP <= pwr_q[PD_OSC] || pwr_q[PD_FULL];
         SYSTEM_CLOCK_INPUT_SLEEP <= pwr_q[PD_SYSTEM_CLOCK_INPUT] ||
                                     pwr_q[PD_FULL];
         REFIN_SLEEP <= pwr_q[PD_REFIN] || pwr_q[PD_FULL];
         TIME_TO_DIGITAL_CONVERTER_SLEEP <=
            pwr_q[PD_TIME_TO_DIGITAL_CONVERTER] || pwr_q[PD_FULL];
         OUTPUT_ANALOG_PLL_SLEEP <= pwr_q[PD_OUTPUT_ANALOG_PLL] ||
                                    pwr_q[PD_FULL];
         DIST_SLEEP <= pwr_q[PD_DIST] || pwr_q[PD_FULL];
         FULL_SLEEP <= pwr_q[PD_FULL];
      end
   end

   // Two-flop synchronisers; only the second flop feeds the logic
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         hist_s_q <= 2'h0;
         plock_s_q <= 2'h0;
         flock_s_q <= 2'h0;
      end else begin
         hist_s_q <= {hist_s_q[0], HISTORY_VALID};
         plock_s_q <= {plock_s_q[0], PHASE_LOCK_RAW};
         flock_s_q <= {flock_s_q[0], FREQ_LOCK_RAW};
      end
   end

   // Loop source choice
   assign hold_f = loop_q[LM_HOLDOVER];
   assign free_f = loop_q[LM_FREERUN];
   always_comb begin
      if (free_f) begin
         loop_d = LOOP_FREERUN;
      end else if (hold_f) begin
         loop_d = hist_s_q[1] ? LOOP_HOLD_HIST : LOOP_FREERUN;
      end else begin
         loop_d = LOOP_NORMAL;
      end
   end

   // Loop controls and lock indications
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         LOOP_SOURCE <= LOOP_NORMAL;
         SWITCH_MODE <= SW_AUTO_REVERT;
         MANUAL_MODE <= 1'b0;
         ACTIVE_REF <= 2'h0;
         PHASE_LOCKED <= 1'b0;
         FREQ_LOCKED <= 1'b0;
      end else begin
         LOOP_SOURCE <= loop_d;
         SWITCH_MODE <= loop_q[LM_SWMODE_HI:LM_SWMODE_LO];
         MANUAL_MODE <= loop_q[LM_SWMODE_HI:LM_SWMODE_LO]
                        inside {SW_MAN_FALLBACK, SW_MAN_HOLDOVER,
                                SW_FULL_MANUAL};
         ACTIVE_REF <= loop_q[LM_REFSEL_HI:LM_REFSEL_LO];
         PHASE_LOCKED <= plock_s_q[1] && !hold_f;
         FREQ_LOCKED <= flock_s_q[1] && !hold_f;
      end
   end

   // Read data mux
   always_comb begin
      rdata_d = 32'h0;
      hit = 1'b1;
      if (in_prof) begin
         rdata_d[7:0] = prof_rdata;
      end else if (idx == GEN_PWR_DOWN_IDX) begin
         rdata_d[7:0] = pwr_q;
      end else if (idx == LOOP_MODE_IDX) begin
         rdata_d[7:0] = loop_q;
      end else if (idx == STATUS_IDX) begin
         rdata_d[0] = PHASE_LOCKED;
         rdata_d[1] = FREQ_LOCKED;
         rdata_d[5:4] = 2'(loop_d);
         rdata_d[6] = hist_s_q[1];
         rdata_d[7] = !SOFT_RESET_N;
      end else begin
         hit = 1'b0;
      end
   end

   // APB answer: one wait-free access, registered in setup
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PRDATA <= 32'h0;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= setup;
         PSLVERR <= setup && !hit;
         if (acc_rd) begin
            PRDATA <= hit ? rdata_d : 32'h0;
         end
      end
   end

   // Free run always wins over holdover on the loop source
   AST_FREE_WINS: assert property (@(posedge CLK) disable iff (!RSTN)
      free_f |=> LOOP_SOURCE == LOOP_FREERUN)
      else $error("free run did not win");
   // Holdover without history falls back to free-run word
   AST_HOLD_SRC: assert property (@(posedge CLK) disable iff (!RSTN)
      hold_f && !free_f && !hist_s_q[1] |=> LOOP_SOURCE == LOOP_FREERUN)
      else $error("holdover source wrong");
   // Forced holdover keeps lock flags low
   AST_LOCK_LOW: assert property (@(posedge CLK) disable iff (!RSTN)
      hold_f |=> !PHASE_LOCKED && !FREQ_LOCKED)
      else $error("lock shown in holdover");
   // Reserved loop-mode bit never reads back
   AST_RSVD: assert property (@(posedge CLK) disable iff (!RSTN)
      (loop_q & ~LOOP_MODE_MASK) == 8'h00)
      else $error("reserved bit set");
   // Soft reset request drives the reset output low
   AST_SRST: assert property (@(posedge CLK) disable iff (!RSTN)
      acc_wr && idx == GEN_PWR_DOWN_IDX && PWDATA[PD_SOFT_RESET]
      |=> ##1 !SOFT_RESET_N)
      else $error("soft reset not driven");
   // Soft reset leaves the loop-mode register intact
   AST_KEEP: assert property (@(posedge CLK) disable iff (!RSTN)
      !SOFT_RESET_N && !(acc_wr && idx == LOOP_MODE_IDX)
      |=> $stable(loop_q))
      else $error("register lost in soft reset");
   // Full sleep forces full, oscillator, converter and distribution sleep
   AST_FULL: assert property (@(posedge CLK) disable iff (!RSTN)
      pwr_q[PD_FULL] |=> FULL_SLEEP && OSC_SLEEP
      && TIME_TO_DIGITAL_CONVERTER_SLEEP && DIST_SLEEP)
      else $error("full sleep incomplete");
   // Oscillator sleep follows its bit
   AST_OSC: assert property (@(posedge CLK) disable iff (!RSTN)
      !pwr_q[PD_FULL] |=> OSC_SLEEP == $past(pwr_q[PD_OSC]))
      else $error("oscillator sleep wrong");
   // Reference input sleep follows bit 4
   AST_REFIN: assert property (@(posedge CLK) disable iff (!RSTN)
      !pwr_q[PD_FULL] |=> REFIN_SLEEP == $past(pwr_q[PD_REFIN]))
      else $error("reference sleep wrong");
   // Manual flag is set for the manual holdover code
   AST_MAN: assert property (@(posedge CLK) disable iff (!RSTN)
      loop_q[LM_SWMODE_HI:LM_SWMODE_LO] == SW_MAN_HOLDOVER |=> MANUAL_MODE)
      else $error("manual mode missed");
endmodule

// >>> rtl/plc_pkg.sv
// Package for the PLL operational controls register bank.
// Assumes a byte-wide register map reached over a 32-bit APB slave.
package plc_pkg;
   // Profile windows: base and last index for each reference
   localparam logic [11:0] PROF_BASE = 12'h700;
   localparam logic [11:0] PROF_LAST = 12'h726;
   localparam logic [11:0] PROF_B_BASE = 12'h740;
   localparam logic [11:0] PROF_B_LAST = 12'h766;
   localparam logic [11:0] PROF_C_BASE = 12'h780;
   localparam logic [11:0] PROF_C_LAST = 12'h7a6;
   localparam logic [11:0] PROF_D_BASE = 12'h7c0;
   localparam logic [11:0] PROF_D_LAST = 12'h7e6;
   localparam int PROF_BYTES = 39;
   localparam int PROF_IDX_W = 6;
   localparam int NUM_REFS = 4;
   // Operational control registers (index; byte address = 4 * index)
   localparam logic [11:0] GEN_PWR_DOWN_IDX = 12'ha00;
   localparam logic [11:0] LOOP_MODE_IDX = 12'ha01;
   localparam logic [11:0] STATUS_IDX = 12'ha10;
   // Power-down register fields
   localparam int PD_SOFT_RESET = 7;
   localparam int PD_OSC = 6;
   localparam int PD_SYSTEM_CLOCK_INPUT = 5;
   localparam int PD_REFIN = 4;
   localparam int PD_TIME_TO_DIGITAL_CONVERTER = 3;
   localparam int PD_OUTPUT_ANALOG_PLL = 2;
   localparam int PD_DIST = 1;
   localparam int PD_FULL = 0;
   localparam logic [7:0] GEN_PWR_DOWN_RST = 8'h00;
   // Loop-mode register fields
   localparam int LM_HOLDOVER = 6;
   localparam int LM_FREERUN = 5;
   localparam int LM_SWMODE_HI = 4;
   localparam int LM_SWMODE_LO = 2;
   localparam int LM_REFSEL_HI = 1;
   localparam int LM_REFSEL_LO = 0;
   localparam logic [7:0] LOOP_MODE_RST = 8'h00;
   localparam logic [7:0] LOOP_MODE_MASK = 8'h7f;
   // Soft reset pulse length in cycles
   localparam logic [3:0] SOFT_RST_CYCLES = 4'h4;
   // Switchover modes
   typedef enum logic [2:0] {
      SW_AUTO_REVERT = 3'h0,
      SW_AUTO_NONREV = 3'h1,
      SW_MAN_FALLBACK = 3'h2,
      SW_MAN_HOLDOVER = 3'h3,
      SW_FULL_MANUAL = 3'h4
   } plc_swmode_type;
   // Loop source selection
   typedef enum logic [1:0] {
      LOOP_NORMAL = 2'h0,
      LOOP_HOLD_HIST = 2'h1,
      LOOP_FREERUN = 2'h3
   } plc_loop_type;
endpackage

// >>> rtl/plc_profile_bank.sv
// Profile byte storage: one identical byte array per input reference.
// Assumes the caller has decoded the reference and byte index.
`timescale 1ns/100ps
module plc_profile_bank
   import plc_pkg::*;
#(
   parameter int REFS = NUM_REFS,
   parameter int BYTES = PROF_BYTES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Access
   input wire logic wr_en,
   input wire logic [1:0] ref_sel,
   input wire logic [PROF_IDX_W-1:0] idx,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem_q [REFS][BYTES];

   // One generate copy per reference, same layout for all
   for (genvar r = 0; r < REFS; r++) begin : g_ref
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            for (int i = 0; i < BYTES; i++) begin
               mem_q[r][i] <= 8'h00;
            end
         end else if (wr_en && ref_sel == 2'(r)) begin
            mem_q[r][idx] <= wdata;
         end
      end
   end

   // Read mux
   assign rdata = mem_q[ref_sel][idx];
endmodule

// >>> dv/tb_pll_operational_controls.sv
// Self-checking bench for the PLL operational controls register bank.
// Assumes the APB slave answers with PREADY and updates outputs on CLK.
`timescale 1ns/100ps
module tb_pll_operational_controls
   import plc_pkg::*;
;
   // Stimulus and observed signals
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, hist = 1'b0, plock = 1'b0, flock = 1'b0;
   logic [13:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, srst_n, er, man, phl, frl;
   logic [6:0] slp;
   logic [1:0] src, aref;
   logic [2:0] swm;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   logic [11:0] base [4] = '{PROF_BASE, PROF_B_BASE, PROF_C_BASE, PROF_D_BASE};

   // 10 MHz clock
   always #50 clk = ~clk;

   // Design under test
   plc_top DUT (
      .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .HISTORY_VALID(hist),
      .PHASE_LOCK_RAW(plock), .FREQ_LOCK_RAW(flock),
      .SOFT_RESET_N(srst_n), .OSC_SLEEP(slp[6]),
      .SYSTEM_CLOCK_INPUT_SLEEP(slp[5]), .REFIN_SLEEP(slp[4]),
      .TIME_TO_DIGITAL_CONVERTER_SLEEP(slp[3]),
      .OUTPUT_ANALOG_PLL_SLEEP(slp[2]),
      .DIST_SLEEP(slp[1]), .FULL_SLEEP(slp[0]), .LOOP_SOURCE(src),
      .SWITCH_MODE(swm), .MANUAL_MODE(man), .ACTIVE_REF(aref),
      .PHASE_LOCKED(phl), .FREQ_LOCKED(frl)
   );

   // Verdict and end of run
   task end_sim();
      $display("errors %0d, checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Compare one value against its expectation
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; byte address is four times the index
   task xfer(input logic w, input logic [11:0] idx, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Read and compare data and error response
   task rdchk(input logic [11:0] idx, input logic [7:0] exp, input logic e);
      xfer(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp});
      chk({31'h0, er}, {31'h0, e});
   endtask

   // Let n edges pass, then sample settled outputs
   task wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Reset values of outputs and registers
   task t_reset();
      wt(1);
      chk({14'h0, srst_n, slp, src, swm, man, aref, phl, frl}, 32'h20000);
      rdchk(GEN_PWR_DOWN_IDX, 8'h00, 1'b0);
      rdchk(LOOP_MODE_IDX, 8'h00, 1'b0);
   endtask

   // Four profile windows hold separate bytes at both ends
   task t_prof();
      for (int r = 0; r < 4; r++)
         for (int o = 0; o < 39; o += 38)
            xfer(1'b1, base[r] + 12'(o), 8'(16 * r + o + 5));
      for (int r = 0; r < 4; r++)
         for (int o = 0; o < 39; o += 38)
            rdchk(base[r] + 12'(o), 8'(16 * r + o + 5), 1'b0);
      rdchk(PROF_LAST + 12'h1, 8'h00, 1'b1);
      rdchk(PROF_D_LAST + 12'h1, 8'h00, 1'b1);
   endtask

   // Bits 1 to 6 drive their own sleep output; full sleep (bit 0) drives all seven
   task t_pd();
      for (int b = 0; b < 7; b++) begin
         xfer(1'b1, GEN_PWR_DOWN_IDX, 8'h01 << b);
         wt(2);
         chk({25'h0, slp},
             b == 0 ? 32'h7f : 32'h1 << b);
         rdchk(GEN_PWR_DOWN_IDX, 8'h01 << b,
               1'b0);
      end
      xfer(1'b1, GEN_PWR_DOWN_IDX, 8'h00);
   endtask

   // Soft reset pulses the logic and keeps programmed values
   task t_srst();
      int n;
      xfer(1'b1, LOOP_MODE_IDX, 8'h0d);
      xfer(1'b1, GEN_PWR_DOWN_IDX, 8'h80);
      wt(1);
      chk({31'h0, srst_n}, 32'h0);
      n = 0;
      while (srst_n !== 1'b1 && n < 20) begin
         wt(1);
         n++;
      end
      chk({31'h0, srst_n}, 32'h1);
      rdchk(LOOP_MODE_IDX, 8'h0d, 1'b0);
      rdchk(GEN_PWR_DOWN_IDX, 8'h00, 1'b0);
   endtask

   // Forced holdover, free run and their precedence
   task t_loop();
      @(posedge clk);
      hist <= 1'b1;
      plock <= 1'b1;
      flock <= 1'b1;
      xfer(1'b1, LOOP_MODE_IDX, 8'h40);
      wt(5);
      chk({30'h0, src}, 32'h1);
      chk({30'h0, phl, frl}, 32'h0);
      rdchk(STATUS_IDX, 8'h50, 1'b0);
      @(posedge clk);
      hist <= 1'b0;
      wt(5);
      chk({30'h0, src}, 32'h3);
      xfer(1'b1, LOOP_MODE_IDX, 8'h20);
      wt(5);
      chk({28'h0, src, phl, frl}, 32'hf);
      @(posedge clk);
      hist <= 1'b1;
      xfer(1'b1, LOOP_MODE_IDX, 8'h60);
      wt(5);
      chk({28'h0, src, phl, frl}, 32'hc);
   endtask

   // Every switchover mode with every manual input choice
   task t_mode();
      for (int m = 0; m < 5; m++)
         for (int a = 0; a < 4; a++) begin
            xfer(1'b1, LOOP_MODE_IDX, {3'h0, 3'(m), 2'(a)});
            wt(2);
            chk({26'h0, swm, man, aref},
                {26'h0, 3'(m), m >= 2, 2'(a)});
         end
      xfer(1'b1, LOOP_MODE_IDX, 8'hff);
      rdchk(LOOP_MODE_IDX, 8'h7f, 1'b0);
      rdchk(12'h800, 8'h00, 1'b1);
   endtask

   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim();
      end
   end

   // Reset, then run the scenarios
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_prof();
      t_pd();
      t_srst();
      t_loop();
      t_mode();
      end_sim();
   end
endmodule
